/* File: hdl/bplmc_top.sv */
`timescale 1ns/10ps
// top: pi loop, transient path, dead-time, emulation, adaptive frequency
module bplmc_top #(
    parameter int DW = 12,
    parameter int CW = 8
) (
    // clock, reset, enable
    input  wire logic            clk_i,
    input  wire logic            sys_rst_i,
    input  wire logic            ce_i,
    // sensed output, reference, regulation window
    input  wire logic [DW-1:0]   vout_i,
    input  wire logic [DW-1:0]   vref_i,
    input  wire logic [DW-1:0]   reg_limit_i,
    // compensation source
    input  wire logic [4:0]      loop_comp_strap_pin_i,
    input  wire logic            coef_serial_i,
    input  wire logic            coef_wr_i,
    input  wire logic [2*CW-1:0] coef_a_i,
    input  wire logic [2*CW-1:0] coef_b_i,
    input  wire logic            adapt_comp_en_i,
    input  wire logic            ntp_serial_en_i,
    input  wire logic [7:0]      load_i,
    // light-load modes
    input  wire logic            diode_emu_en_i,
    input  wire logic            multi_phase_i,
    input  wire logic [7:0]      de_load_thresh_i,
    input  wire logic            il_zero_i,
    input  wire logic [7:0]      misc_config_i,
    input  wire logic            share_group_i,
    input  wire logic            sync_auto_i,
    input  wire logic            sync_clk_present_i,
    input  wire logic            sync_clk_out_i,
    // frequency and nominal duty
    input  wire logic [15:0]     switching_freq_command_i,
    input  wire logic [15:0]     fmin_khz_i,
    input  wire logic [9:0]      nominal_duty_i,
    // drives and status
    output logic                 high_side_gate_drive_o,
    output logic                 low_side_gate_drive_o,
    output logic [9:0]           duty_o,
    output logic [15:0]          period_o,
    output logic [5:0]           dead_time_o,
    output logic                 ntp_active_o,
    output logic                 de_active_o,
    output logic                 af_active_o
);
    localparam int IW = 21;

    logic [4:0]             strap_reg;
    logic                   strap_pend_reg;
    logic [2*CW-1:0]        coef_a_reg;
    logic [2*CW-1:0]        coef_b_reg;
    logic signed [IW-1:0]   integ_reg;
    logic [9:0]             duty_prev_reg;
    logic                   dt_up_reg;
    logic                   force_hi_reg;
    logic                   force_lo_reg;
    bplmc_pkg::bplmc_div_t  div_st_reg;
    logic [4:0]             div_cnt_reg;
    logic [17:0]            div_num_reg;
    logic [16:0]            div_rem_reg;
    logic [17:0]            div_quo_reg;
    logic [15:0]            div_den_reg;
    logic                   start;

    function automatic logic [CW-1:0] blend(input logic [CW-1:0] a,
                                            input logic [CW-1:0] b,
                                            input logic [7:0]    w);
        logic signed [CW:0]   d;
        logic signed [CW+9:0] p;
        d = $signed({1'b0, b}) - $signed({1'b0, a});
        p = d * $signed({1'b0, w});
        blend = CW'($signed({1'b0, a}) + (p >>> 8));
    endfunction

    // coefficient selection
    logic [15:0]   strap_kk;
    logic [CW-1:0] kp_w;
    logic [CW-1:0] ki_w;
    logic          ntp_on;
    assign strap_kk = bplmc_pkg::strap_coef(strap_reg);
    // serial set wins over the strap once selected
    assign kp_w = !coef_serial_i ? strap_kk[15:8] :
                  adapt_comp_en_i ? blend(coef_a_reg[2*CW-1:CW],
                                          coef_b_reg[2*CW-1:CW], load_i) :
                  coef_a_reg[2*CW-1:CW];
    assign ki_w = !coef_serial_i ? strap_kk[7:0] :
                  adapt_comp_en_i ? blend(coef_a_reg[CW-1:0],
                                          coef_b_reg[CW-1:0], load_i) :
                  coef_a_reg[CW-1:0];
    assign ntp_on = coef_serial_i ? ntp_serial_en_i
                                  : (strap_reg >= bplmc_pkg::NTP_FIRST);

    // error, integrator and duty
    logic signed [DW:0]      err;
    logic signed [DW+CW+1:0] prod_i_w;
    logic signed [DW+CW+1:0] prod_p_w;
    logic signed [IW+1:0]    isum_w;
    logic signed [IW-1:0]    integ_next;
    logic signed [IW+1:0]    dsum_w;
    logic [9:0]              duty_next;
    assign err = $signed({vref_i[DW-1], vref_i})
               - $signed({vout_i[DW-1], vout_i});
    assign prod_i_w = err * $signed({1'b0, ki_w});
    assign prod_p_w = err * $signed({1'b0, kp_w});
    assign isum_w = integ_reg + prod_i_w;
    assign integ_next = (isum_w < 0) ? '0 :
                        (isum_w > bplmc_pkg::INT_MAX) ?
                        IW'(bplmc_pkg::INT_MAX) : IW'(isum_w);
    assign dsum_w = (integ_reg >>> bplmc_pkg::INT_SHIFT)
                  + (prod_p_w >>> bplmc_pkg::P_SHIFT);
    assign duty_next = (dsum_w < 0) ? 10'h000 :
                       (dsum_w > $signed({13'h0000, bplmc_pkg::DUTY_MAX})) ?
                       bplmc_pkg::DUTY_MAX : dsum_w[9:0];

    // nonlinear transient path
    logic under_w;
    logic over_w;
    assign under_w = ntp_on && (err > $signed({1'b0, reg_limit_i}));
    assign over_w  = ntp_on && (-err > $signed({1'b0, reg_limit_i}));

    // dead-time steering
    logic       dt_dir_next;
    logic [5:0] dt_next;
    // a wider duty after the last step means the step went the wrong way
    assign dt_dir_next = (duty_o > duty_prev_reg) ? ~dt_up_reg : dt_up_reg;
    assign dt_next = dt_dir_next ?
        ((dead_time_o >= bplmc_pkg::DT_MAX) ? bplmc_pkg::DT_MAX
                                            : dead_time_o + 6'h01) :
        ((dead_time_o <= bplmc_pkg::DT_MIN) ? bplmc_pkg::DT_MIN
                                            : dead_time_o - 6'h01);

    // light-load modes
    logic de_next;
    logic af_next;
    logic af_low;
    assign de_next = diode_emu_en_i & ~multi_phase_i
                   & (load_i < de_load_thresh_i);
    assign af_next = misc_config_i[bplmc_pkg::MISC_AF_BIT] & de_next
                   & ~share_group_i & ~(sync_auto_i & sync_clk_present_i)
                   & ~sync_clk_out_i;
    assign af_low = af_active_o && (duty_o < {1'b0, nominal_duty_i[9:1]});

    // quantized level: count of j/8 steps that 2D/Dnom has passed
    logic [2:0]  af_lvl;
    logic [18:0] fstep;
    logic [15:0] f_tgt;
    logic [15:0] f_sel;
    always_comb begin
        af_lvl = 3'h0;
        for (int j = 1; j < 8; j++) begin
            if ({duty_o, 4'h0} >= 14'(j) * {4'h0, nominal_duty_i}) begin
                af_lvl = 3'(j);
            end
        end
    end
    assign fstep = (switching_freq_command_i - fmin_khz_i) * af_lvl;
    assign f_tgt = fmin_khz_i + fstep[18:3];
    // fixed frequency whenever the reduction is off or not below half
    assign f_sel = (af_low && switching_freq_command_i > fmin_khz_i)
                 ? f_tgt : switching_freq_command_i;

    // restoring divider turns the frequency into a period in clocks
    logic [16:0] rem_sh;
    logic        rem_ge;
    logic [15:0] per_q;
    assign rem_sh = {div_rem_reg[15:0], div_num_reg[17]};
    assign rem_ge = rem_sh >= {1'b0, div_den_reg};
    assign per_q  = (div_quo_reg[17:16] != 2'b00) ? 16'hffff :
                    (div_quo_reg[15:0] < bplmc_pkg::PER_MIN) ?
                    bplmc_pkg::PER_MIN : div_quo_reg[15:0];

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            strap_pend_reg <= 1'b1;
            strap_reg      <= 5'h00;
            coef_a_reg     <= bplmc_pkg::COEF_RST;
            coef_b_reg     <= bplmc_pkg::COEF_RST;
        end else if (ce_i) begin
            strap_pend_reg <= 1'b0;
            // strap caught once after reset; out-of-range codes fall to 0
            if (strap_pend_reg) begin
                strap_reg <= (loop_comp_strap_pin_i <
                              5'(bplmc_pkg::STRAP_CODES))
                             ? loop_comp_strap_pin_i : 5'h00;
            end
            if (coef_wr_i) begin
                coef_a_reg <= coef_a_i;
                coef_b_reg <= coef_b_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            integ_reg     <= '0;
            duty_o        <= bplmc_pkg::DUTY_RST;
            duty_prev_reg <= bplmc_pkg::DUTY_RST;
            dt_up_reg     <= 1'b0;
            dead_time_o   <= bplmc_pkg::DT_RST;
        end else if (ce_i && start) begin
            // integrator holds while the transient path has control
            if (!(under_w || over_w)) begin
                integ_reg <= integ_next;
            end
            duty_o        <= duty_next;
            duty_prev_reg <= duty_o;
            dt_up_reg     <= dt_dir_next;
            dead_time_o   <= dt_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            force_hi_reg <= 1'b0;
            force_lo_reg <= 1'b0;
            ntp_active_o <= 1'b0;
            de_active_o  <= 1'b0;
            af_active_o  <= 1'b0;
        end else if (ce_i) begin
            force_hi_reg <= under_w;
            force_lo_reg <= over_w;
            ntp_active_o <= under_w | over_w;
            de_active_o  <= de_next;
            af_active_o  <= af_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            div_st_reg  <= bplmc_pkg::DIV_IDLE;
            div_cnt_reg <= 5'h00;
            div_num_reg <= 18'h00000;
            div_rem_reg <= 17'h00000;
            div_quo_reg <= 18'h00000;
            div_den_reg <= 16'h0001;
            period_o    <= bplmc_pkg::PER_RST;
        end else if (ce_i) begin
            case (div_st_reg)
                bplmc_pkg::DIV_IDLE: begin
                    if (start) begin
                        div_st_reg  <= bplmc_pkg::DIV_RUN;
                        div_cnt_reg <= 5'h00;
                        div_num_reg <= bplmc_pkg::CLK_KHZ_W;
                        div_rem_reg <= 17'h00000;
                        div_quo_reg <= 18'h00000;
                        div_den_reg <= (f_sel == 16'h0000) ? 16'h0001
                                                           : f_sel;
                    end
                end
                bplmc_pkg::DIV_RUN: begin
                    div_num_reg <= {div_num_reg[16:0], 1'b0};
                    div_rem_reg <= rem_ge ? rem_sh - {1'b0, div_den_reg}
                                          : rem_sh;
                    div_quo_reg <= {div_quo_reg[16:0], rem_ge};
                    div_cnt_reg <= div_cnt_reg + 5'h01;
                    if (div_cnt_reg == 5'(bplmc_pkg::DIV_STEPS)) begin
                        div_st_reg <= bplmc_pkg::DIV_IDLE;
                        period_o   <= per_q;
                    end
                end
                default: div_st_reg <= bplmc_pkg::DIV_IDLE;
            endcase
        end
    end

    bplmc_gate u_gate (
        .clk_i      (clk_i),
        .sys_rst_i  (sys_rst_i),
        .ce_i       (ce_i),
        .period_i   (period_o),
        .duty_i     (duty_o),
        .dead_i     (dead_time_o),
        .force_hi_i (force_hi_reg),
        .force_lo_i (force_lo_reg),
        .de_i       (de_active_o),
        .il_zero_i  (il_zero_i),
        .hs_o       (high_side_gate_drive_o),
        .ls_o       (low_side_gate_drive_o),
        .start_o    (start)
    );

    a_ntp_high: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && under_w |=> force_hi_reg && !force_lo_reg)
        else $error("undershoot did not force high side");
    a_ntp_low: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && over_w |=> force_lo_reg && !force_hi_reg)
        else $error("overshoot did not force low side");
    a_strap_ntp: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        !coef_serial_i && strap_reg < 5'h09 |-> !ntp_on)
        else $error("transient path on for a low strap code");
    a_de_single: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && multi_phase_i |=> !de_active_o)
        else $error("emulation active in multi-phase");
    a_af_inhibit: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && (share_group_i || sync_clk_out_i
                 || (sync_auto_i && sync_clk_present_i)) |=> !af_active_o)
        else $error("adaptive frequency not inhibited");
    a_af_needs_de: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        af_active_o |-> de_active_o && $past(misc_config_i[0]))
        else $error("adaptive frequency without emulation");
    a_dt_bounds: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        dead_time_o >= 6'h01 && dead_time_o <= 6'h3f)
        else $error("dead time out of range");
    a_duty_step: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && start |=> duty_o == $past(duty_next))
        else $error("duty not updated at period start");
    a_div_time: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && start && div_st_reg == bplmc_pkg::DIV_IDLE
        |=> div_st_reg == bplmc_pkg::DIV_RUN [*8])
        else $error("period divider ended early");
    c_ntp_high: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(force_hi_reg));
    c_af_on: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        af_low && af_lvl != 3'h0);
    c_dt_turn: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        start && dt_dir_next != dt_up_reg);
endmodule

/* File: hdl/bplmc_pkg.sv */
// package: constants and strap table for the buck pwm loop block
// Function
// - voltage-mode pi loop sets gate duty cycle
// - zeros from strap or serial coefficients
// - strap settings target fsw/20, 60 degrees
// - eighteen strap codes, upper nine enable transient path
// - serial load holds second set, adaptive blend
// - transient path bypasses loop outside limits
// - undershoot forces high side, overshoot low
// - high and low drives never overlap
// - closed-loop dead-time steers toward minimum duty
// - diode emulation cuts low side at zero
// - diode emulation only in single phase
// - misc bit0 enables adaptive freq, needs emulation
// - light load shortens low then high time
// - below half nominal duty, frequency scales
// - reduced frequency moves in quantized steps
// - adaptive freq inhibited by share or sync
package bplmc_pkg;
    localparam int          CLK_PERIOD_NS = 4;
    localparam int          CLK_KHZ       = 1000000 / CLK_PERIOD_NS;
    localparam logic [17:0] CLK_KHZ_W     = 18'(CLK_KHZ);
    localparam int          STRAP_CODES   = 18;
    localparam logic [4:0]  NTP_FIRST     = 5'h09;
    localparam int          MISC_AF_BIT   = 0;
    localparam int          INT_SHIFT     = 8;
    localparam int          P_SHIFT       = 4;
    localparam int          AF_LVL_LOG2   = 3;
    localparam logic [9:0]  DUTY_MAX      = 10'h3ff;
    localparam logic [9:0]  DUTY_RST      = 10'h000;
    localparam int          INT_MAX       = 1023 * 256;
    localparam logic [5:0]  DT_RST        = 6'h08;
    localparam logic [5:0]  DT_MIN        = 6'h01;
    localparam logic [5:0]  DT_MAX        = 6'h3f;
    localparam logic [15:0] PER_RST       = 16'h01f4;
    localparam logic [15:0] PER_MIN       = 16'h0080;
    localparam logic [15:0] COEF_RST      = 16'h0000;
    localparam int          DIV_STEPS     = 18;

    typedef enum logic [1:0] {
        DIV_IDLE = 2'b01,
        DIV_RUN  = 2'b10
    } bplmc_div_t;

    // {kp, ki} per band pair, tuned for fsw/20 crossover and 60 deg margin
    function automatic logic [15:0] strap_coef(input logic [4:0] code);
        logic [4:0] band;
        band = (code >= NTP_FIRST) ? code - NTP_FIRST : code;
        case (band)
            5'h00:   strap_coef = 16'h3010;
            5'h01:   strap_coef = 16'h2810;
            5'h02:   strap_coef = 16'h200c;
            5'h03:   strap_coef = 16'h2008;
            5'h04:   strap_coef = 16'h1808;
            5'h05:   strap_coef = 16'h1406;
            5'h06:   strap_coef = 16'h1004;
            5'h07:   strap_coef = 16'h0c04;
            default: strap_coef = 16'h0803;
        endcase
    endfunction
endpackage

/* File: hdl/bplmc_gate.sv */
`timescale 1ns/10ps
// gate drive sequencer: period counter, dead-time and emulation cut
module bplmc_gate (
    // clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    // timing
    input  wire logic [15:0] period_i,
    input  wire logic [9:0]  duty_i,
    input  wire logic [5:0]  dead_i,
    // overrides
    input  wire logic        force_hi_i,
    input  wire logic        force_lo_i,
    input  wire logic        de_i,
    input  wire logic        il_zero_i,
    // drives
    output logic             hs_o,
    output logic             ls_o,
    output logic             start_o
);
    logic [15:0] cnt_reg;
    logic [15:0] per_reg;
    logic [15:0] hi_len_reg;
    logic        cut_reg;
    logic [25:0] hi_prod;
    logic        wrap;
    logic [16:0] hs_end;
    logic [17:0] ls_beg;
    logic        want_hs;
    logic        want_ls;
    logic        cut_next;

    assign hi_prod = duty_i * period_i;
    assign wrap    = (cnt_reg >= per_reg - 16'h0001);
    assign hs_end  = {11'h000, dead_i} + {1'b0, hi_len_reg};
    assign ls_beg  = {1'b0, hs_end} + {12'h000, dead_i};
    // force overrides sit outside the duty window, only a one-clock break kept
    assign want_hs = force_hi_i | (~force_lo_i
                     & ({1'b0, cnt_reg} >= {11'h000, dead_i})
                     & ({1'b0, cnt_reg} < hs_end));
    // low side waits one dead-time after the high pulse ends
    assign want_ls = force_lo_i | (~force_hi_i & ~cut_reg
                     & ({2'b00, cnt_reg} >= ls_beg));
    // a cut that lands on the wrap cycle still wins
    assign cut_next = (de_i & il_zero_i & ls_o) | (cut_reg & ~wrap);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_reg    <= 16'h0000;
            per_reg    <= bplmc_pkg::PER_RST;
            hi_len_reg <= 16'h0000;
            cut_reg    <= 1'b0;
            hs_o       <= 1'b0;
            ls_o       <= 1'b0;
            start_o    <= 1'b0;
        end else if (ce_i) begin
            cnt_reg <= wrap ? 16'h0000 : cnt_reg + 16'h0001;
            start_o <= wrap;
            cut_reg <= cut_next;
            if (wrap) begin
                per_reg    <= period_i;
                hi_len_reg <= hi_prod[25:10];
            end
            hs_o <= want_hs & ~ls_o & ~want_ls;
            ls_o <= want_ls & ~hs_o & ~want_hs;
        end
    end

    a_no_overlap: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        !(hs_o && ls_o)) else $error("both gate drives on");
    a_de_cut_hold: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && cut_reg && !force_lo_i |=> !ls_o)
        else $error("low side on during emulation cut");
    a_ls_gap: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && hs_o |=> !ls_o) else $error("low side right after high");
    c_cut_seen: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(cut_reg));
endmodule

/* File: sim/bplmc_stage_model.sv */
// behavioural gate driver and buck power stage on the far side
`timescale 1ns/10ps
module bplmc_stage_model (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          sys_rst_i,
    // gate drives, minimum clear
    input  wire logic          hs_i,
    input  wire logic          ls_i,
    input  wire logic          clr_i,
    // plant outputs
    output logic        [11:0] vout_o,
    output logic               il_zero_o,
    output logic               overlap_o,
    output logic signed [15:0] il_min_o
);
    logic signed [15:0] il_reg;
    logic        [17:0] v_reg;
    assign vout_o    = v_reg[17:6];
    assign il_zero_o = (il_reg <= 16'sh0000);
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            il_reg    <= 16'sh0000;
            v_reg     <= 18'h00000;
            overlap_o <= 1'b0;
            il_min_o  <= 16'sh7fff;
        end else begin
            // with both gates off a body diode drains toward zero
            if (hs_i)
                il_reg <= il_reg + 16'sh0004;
            else if (ls_i)
                il_reg <= il_reg - 16'sh0004;
            else if (il_reg > 16'sh0000)
                il_reg <= il_reg - 16'sh0001;
            else if (il_reg < 16'sh0000)
                il_reg <= il_reg + 16'sh0001;
            v_reg <= v_reg + 18'(il_reg) - (v_reg >> 8);
            if (hs_i && ls_i)
                overlap_o <= 1'b1;
            if (clr_i)
                il_min_o <= 16'sh7fff;
            else if (il_reg < il_min_o)
                il_min_o <= il_reg;
        end
    end
endmodule

/* File: sim/buck_pwm_loop_mode_control_tb.sv */
// self-checking bench for the buck pwm loop and mode control
`timescale 1ns/10ps
module buck_pwm_loop_mode_control_tb;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, ovr = 1'b1, clr = 1'b0;
    logic [11:0] vref_i = 12'h400, reg_limit_i = 12'h040, ovr_v = 12'h400;
    logic [4:0] strap = 5'h00;
    logic coef_serial_i = 1'b0, coef_wr_i = 1'b0, adapt_comp_en_i = 1'b0;
    logic ntp_serial_en_i = 1'b0, diode_emu_en_i = 1'b0, multi_phase_i = 1'b0;
    logic [15:0] coef_a_i = 16'h2010, coef_b_i = 16'h1008;
    logic [7:0] load_i = 8'h0a, thr = 8'h14, misc_config_i = 8'h00;
    logic [3:0] inh = 4'h0;
    logic [15:0] fsw = 16'h03e8, fmin = 16'h00fa;
    logic [9:0] nominal_duty_i = 10'h200, d0;
    wire [11:0] plant_v, vout_i;
    wire hs, ls, ntp, de, af, il_zero, overlap;
    wire [9:0] duty;
    wire [15:0] period;
    wire [5:0] dead;
    wire signed [15:0] il_min;
    int errors = 0, checks = 0, since = 0, gap = 0, i;
    logic ls_q = 1'b0, dt_moved = 1'b0;
    assign vout_i = ovr ? ovr_v : plant_v;
    bplmc_top #(.DW(12), .CW(8)) bplmc_top_inst (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
        .vout_i(vout_i), .vref_i(vref_i), .reg_limit_i(reg_limit_i),
        .loop_comp_strap_pin_i(strap), .coef_serial_i(coef_serial_i),
        .coef_wr_i(coef_wr_i), .coef_a_i(coef_a_i), .coef_b_i(coef_b_i),
        .adapt_comp_en_i(adapt_comp_en_i), .ntp_serial_en_i(ntp_serial_en_i),
        .load_i(load_i), .diode_emu_en_i(diode_emu_en_i),
        .multi_phase_i(multi_phase_i), .de_load_thresh_i(thr),
        .il_zero_i(il_zero), .misc_config_i(misc_config_i),
        .share_group_i(inh[0]), .sync_auto_i(inh[1] | inh[2]),
        .sync_clk_present_i(inh[1]), .sync_clk_out_i(inh[3]),
        .switching_freq_command_i(fsw), .fmin_khz_i(fmin),
        .nominal_duty_i(nominal_duty_i), .high_side_gate_drive_o(hs),
        .low_side_gate_drive_o(ls), .duty_o(duty), .period_o(period),
        .dead_time_o(dead), .ntp_active_o(ntp), .de_active_o(de),
        .af_active_o(af));
    bplmc_stage_model bplmc_stage_model_inst (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .hs_i(hs), .ls_i(ls),
        .clr_i(clr), .vout_o(plant_v), .il_zero_o(il_zero),
        .overlap_o(overlap), .il_min_o(il_min));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // gap between low-side falls: one clock after each wrap whatever
    // the dead-time; and whether dead-time ever moved
    always @(posedge clk_i) begin
        ls_q <= ls;
        since <= since + 1;
        if (!ls && ls_q) begin
            gap <= since;
            since <= 1;
        end
        if (!sys_rst_i && dead !== 6'h08)
            dt_moved <= 1'b1;
    end
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // strap is held until well past the capture edge after release
    task automatic do_reset(input logic [4:0] code);
        @(negedge clk_i);
        sys_rst_i = 1'b1;
        strap = code;
        cyc(2);
        sys_rst_i = 1'b0;
        cyc(2);
    endtask
    // quantised period set, one count of rounding slack
    function automatic logic per_ok(input logic [15:0] p);
        int k;
        int q;
        per_ok = 1'b0;
        for (k = 0; k < 8; k++) begin
            q = 250000 / (250 + (750 * k) / 8);
            if (p >= q - 1 && p <= q + 1)
                per_ok = 1'b1;
        end
    endfunction
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        tally_and_finish;
    end
    initial begin
        cyc(2);
        sys_rst_i = 1'b0;
        check({hs, ls, duty, period, dead, ntp, de, af}, 37'h00003e840);
        $display("test reset done");
        ovr_v = 12'h300;
        for (i = 0; i < 18; i++) begin
            do_reset(5'(i));
            cyc(10);
            check(ntp, i >= 9);
            if (i >= 9)
                check({hs, ls}, 2'b10);
        end
        ovr_v = 12'h500;
        cyc(10);
        check({ntp, hs, ls}, 3'b101);
        $display("test strap and transient done");
        ovr_v = 12'h3c0;
        cyc(1500);
        check(duty > 10'h000, 1'b1);
        check(period, 16'h00fa);
        check(gap, 250);
        d0 = duty;
        ovr_v = 12'h404;
        cyc(800);
        check(duty < d0, 1'b1);
        $display("test loop and period done");
        do_reset(5'h00);
        coef_serial_i = 1'b1;
        coef_wr_i = 1'b1;
        adapt_comp_en_i = 1'b1;
        load_i = 8'h80;
        cyc(1);
        coef_wr_i = 1'b0;
        ovr_v = 12'h300;
        cyc(10);
        check(ntp, 1'b0);
        ntp_serial_en_i = 1'b1;
        cyc(10);
        check({ntp, hs, ls}, 3'b110);
        $display("test serial coefficients done");
        ovr_v = 12'h400;
        load_i = 8'h0a;
        diode_emu_en_i = 1'b1;
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        cyc(1500);
        check(de, 1'b1);
        check(il_min >= -16, 1'b1);
        multi_phase_i = 1'b1;
        cyc(3);
        check(de, 1'b0);
        multi_phase_i = 1'b0;
        load_i = 8'h1e;
        cyc(3);
        check(de, 1'b0);
        load_i = 8'h0a;
        $display("test diode emulation done");
        misc_config_i = 8'h01;
        cyc(3);
        check(af, 1'b1);
        for (i = 0; i < 4; i++) begin
            inh = 4'h1 << i;
            cyc(3);
            check(af, i == 2);
        end
        inh = 4'h0;
        diode_emu_en_i = 1'b0;
        cyc(3);
        check(af, 1'b0);
        diode_emu_en_i = 1'b1;
        ovr_v = 12'h43f;
        cyc(4000);
        check(per_ok(period), 1'b1);
        check(period > 16'h00fa, 1'b1);
        misc_config_i = 8'h00;
        cyc(3000);
        check(period, 16'h00fa);
        diode_emu_en_i = 1'b0;
        ovr_v = 12'h300;
        cyc(10);
        check(ntp, 1'b1);
        ce_i = 1'b0;
        ovr_v = 12'h500;
        cyc(10);
        check({ntp, hs, ls}, 3'b110);
        ce_i = 1'b1;
        cyc(10);
        check({ntp, hs, ls}, 3'b101);
        $display("test adaptive frequency done");
        check(overlap, 1'b0);
        check(dt_moved, 1'b1);
        tally_and_finish;
    end
endmodule
